//--- twowire_slave_tx_status.sv
// Two-wire slave transmitter with status codes, bus error recovery and start queue
`default_nettype none

module twowire_slave_tx_status
  import twowire_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [ADDR_BITS-1:0] own_addr_i,
  input wire logic general_call_enable_i,
  input wire logic arb_lost_i,
  input wire logic ctrl_write_i,
  input wire logic ctrl_flag_i,
  input wire logic ctrl_ack_i,
  input wire logic ctrl_start_i,
  input wire logic ctrl_stop_i,
  input wire logic data_write_i,
  input wire logic [DATA_BITS-1:0] data_i,
  output logic [DATA_BITS-1:0] status_o,
  output logic step_done_flag_o,
  output logic ack_enable_o,
  output logic start_request_o,
  output logic stop_request_bit_o,
  output logic [DATA_BITS-1:0] serial_data_o,
  output logic start_pending_o,
  output logic start_launch_o,
  output logic bus_owned_o,
  output logic bus_busy_o
);
  localparam int CFG_W = DATA_BITS + ADDR_BITS + 4;

  // System domain state
  logic flag_q;
  logic [DATA_BITS-1:0] status_q;
  logic ack_en_q;
  logic start_q;
  logic stop_q;
  logic [DATA_BITS-1:0] data_q;
  logic rel_tgl_q;
  logic pend_q;
  logic launch_q;
  logic own_q;
  logic ev_seen_q;
  logic busy_prev_q;
  logic [1:0] link_s;
  logic ev_pulse;
  logic busy_s;
  logic flag_clear;
  logic in_hold_code;
  logic in_end_code;

  // Link domain state
  link_state_t lstate_q;
  logic [2:0] bit_cnt_q;
  logic [DATA_BITS-1:0] shift_q;
  logic last_q;
  logic sda_low_q;
  logic scl_low_q;
  logic ev_tgl_q;
  logic [DATA_BITS-1:0] ev_code_q;
  logic busy_q;
  logic scl_p_q;
  logic sda_p_q;
  logic rel_seen_q;
  logic [1:0] pin_s;
  logic [CFG_W-1:0] cfg_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic rel_pulse;
  logic frame_active;
  logic [DATA_BITS-1:0] data_s;
  logic [ADDR_BITS-1:0] own_s;
  logic ack_s;
  logic gce_s;
  logic arb_s;
  logic [ADDR_BITS-1:0] rx_addr;
  logic addr_hit;

  // Link pins and settings into the link domain
  bit_sync #(.WIDTH(2), .INIT(2'h3)) u_pin_sync (
    .clk_i(link_clk_i),
    .reset_n_i(reset_n_i),
    .d_i({scl_i, sda_i}),
    .q_o(pin_s)
  );

  bit_sync #(.WIDTH(CFG_W)) u_cfg_sync (
    .clk_i(link_clk_i),
    .reset_n_i(reset_n_i),
    .d_i({data_q, own_addr_i, ack_en_q, general_call_enable_i, arb_lost_i, rel_tgl_q}),
    .q_o(cfg_s)
  );

  // Link events and bus activity into the system domain
  bit_sync #(.WIDTH(2)) u_link_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i({ev_tgl_q, busy_q}),
    .q_o(link_s)
  );

  assign {data_s, own_s, ack_s, gce_s, arb_s} = cfg_s[CFG_W-1:1];
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rel_pulse = cfg_s[0] ^ rel_seen_q;
  assign rx_addr = shift_q[ADDR_BITS-1:0];
  // Own address always, general call only with its enable, both gated by ack enable
  assign addr_hit = ack_s & ((rx_addr == own_s) |
                    (gce_s & (rx_addr == GENERAL_CALL_ADDR)));

  always_comb begin
    case (lstate_q)
      L_ADDR: frame_active = (bit_cnt_q != '0);
      L_ADDR_ACK, L_HOLD, L_TX, L_TX_ACK, L_TX_POST: frame_active = 1'b1;
      default: frame_active = 1'b0;
    endcase
  end

  // Pin history and release edge tracking
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      rel_seen_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      rel_seen_q <= cfg_s[0];
    end
  end

  // Bus busy between a start and a stop; repeated starts keep it set
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_q <= 1'b0;
    end else if (start_c) begin
      busy_q <= 1'b1;
    end else if (stop_c) begin
      busy_q <= 1'b0;
    end
  end

  // Link sequencer
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lstate_q <= L_IDLE;
      bit_cnt_q <= '0;
      shift_q <= '0;
      last_q <= 1'b0;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
      ev_tgl_q <= 1'b0;
      ev_code_q <= ST_NO_INFO;
    end else if ((start_c || stop_c) && frame_active) begin
      ev_tgl_q <= ~ev_tgl_q;
      ev_code_q <= ST_BUS_ERROR;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
      lstate_q <= L_SKIP;
    end else begin
      case (lstate_q)
        L_IDLE, L_SKIP: begin
          // Unaddressed: data stays released so a master reads ones
          sda_low_q <= 1'b0;
          scl_low_q <= 1'b0;
          if (start_c) begin
            lstate_q <= L_ADDR;
            bit_cnt_q <= '0;
          end else if (stop_c) begin
            lstate_q <= L_IDLE;
          end
        end
        L_ADDR: begin
          if (start_c) begin
            bit_cnt_q <= '0;
          end else if (stop_c) begin
            lstate_q <= L_IDLE;
          end else if (scl_rise) begin
            shift_q <= {shift_q[DATA_BITS-2:0], sda_s};
            bit_cnt_q <= bit_cnt_q + BIT_STEP;
            if (bit_cnt_q == LAST_BIT_IDX) begin
              // shift_q holds the seven address bits, sda_s is the direction bit
              if (addr_hit && sda_s && (rx_addr == own_s)) begin
                lstate_q <= L_ADDR_ACK;
              end else begin
                lstate_q <= L_SKIP;
              end
            end
          end
        end
        L_ADDR_ACK: begin
          if (scl_fall && !sda_low_q) begin
            sda_low_q <= 1'b1;
          end else if (scl_fall) begin
            sda_low_q <= 1'b0;
            scl_low_q <= 1'b1;
            ev_tgl_q <= ~ev_tgl_q;
            ev_code_q <= arb_s ? ST_ARB_READ : ST_OWN_READ;
            lstate_q <= L_HOLD;
          end
        end
        L_HOLD: begin
          // Clock held low until software releases the step
          if (rel_pulse) begin
            shift_q <= data_s;
            sda_low_q <= ~data_s[DATA_BITS-1];
            last_q <= ~ack_s;
            scl_low_q <= 1'b0;
            bit_cnt_q <= '0;
            lstate_q <= L_TX;
          end
        end
        L_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == LAST_BIT_IDX) begin
              sda_low_q <= 1'b0;
              lstate_q <= L_TX_ACK;
            end else begin
              shift_q <= {shift_q[DATA_BITS-2:0], 1'b0};
              sda_low_q <= ~shift_q[DATA_BITS-2];
              bit_cnt_q <= bit_cnt_q + BIT_STEP;
            end
          end
        end
        L_TX_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              ev_tgl_q <= ~ev_tgl_q;
              ev_code_q <= ST_DATA_NACK;
              lstate_q <= L_SKIP;
            end else if (last_q) begin
              ev_tgl_q <= ~ev_tgl_q;
              ev_code_q <= ST_LAST_ACK;
              lstate_q <= L_SKIP;
            end else begin
              lstate_q <= L_TX_POST;
            end
          end
        end
        L_TX_POST: begin
          if (scl_fall) begin
            ev_tgl_q <= ~ev_tgl_q;
            ev_code_q <= ST_DATA_ACK;
            scl_low_q <= 1'b1;
            lstate_q <= L_HOLD;
          end
        end
        default: lstate_q <= L_IDLE;
      endcase
    end
  end

  // System side decode
  assign ev_pulse = link_s[1] ^ ev_seen_q;
  assign busy_s = link_s[0];
  assign flag_clear = ctrl_write_i & ctrl_flag_i & flag_q;
  assign in_hold_code = (status_q == ST_OWN_READ) || (status_q == ST_ARB_READ) ||
                        (status_q == ST_DATA_ACK);
  assign in_end_code = (status_q == ST_DATA_NACK) || (status_q == ST_LAST_ACK);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_seen_q <= 1'b0;
      busy_prev_q <= 1'b0;
    end else begin
      ev_seen_q <= link_s[1];
      busy_prev_q <= busy_s;
    end
  end

  // Step done flag and status; a new event wins over a clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_q <= 1'b0;
      status_q <= ST_NO_INFO;
    end else if (ev_pulse) begin
      flag_q <= 1'b1;
      status_q <= ev_code_q & PRESCALE_MASK;
    end else if (flag_clear) begin
      flag_q <= 1'b0;
      status_q <= ST_NO_INFO;
    end
  end

  // Control bits; bus error recovery clears only the stop bit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_en_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (ctrl_write_i) begin
      ack_en_q <= ctrl_ack_i;
      start_q <= ctrl_start_i;
      if (flag_clear && (status_q == ST_BUS_ERROR) && ctrl_stop_i) begin
        stop_q <= 1'b0;
      end else begin
        stop_q <= ctrl_stop_i;
      end
    end
  end

  // Data register only ever holds what software loaded
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_q <= '0;
    end else if (data_write_i) begin
      data_q <= data_i;
    end
  end

  // Release the held clock after a transmit step with the stop bit low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rel_tgl_q <= 1'b0;
    end else if (flag_clear && in_hold_code && !ctrl_stop_i) begin
      rel_tgl_q <= ~rel_tgl_q;
    end
  end

  // Start queue and bus ownership
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_q <= 1'b0;
      launch_q <= 1'b0;
      own_q <= 1'b0;
    end else begin
      launch_q <= 1'b0;
      if (flag_clear && in_end_code && ctrl_start_i) begin
        pend_q <= 1'b1;
      end else if (pend_q && !busy_s) begin
        pend_q <= 1'b0;
        launch_q <= 1'b1;
        own_q <= 1'b1;
      end else if (busy_prev_q && !busy_s) begin
        own_q <= 1'b0;
      end
    end
  end

  assign scl_o = LINE_LOW;
  assign sda_o = LINE_LOW;
  assign scl_oe_o = scl_low_q;
  assign sda_oe_o = sda_low_q;
  assign status_o = status_q;
  assign step_done_flag_o = flag_q;
  assign ack_enable_o = ack_en_q;
  assign start_request_o = start_q;
  assign stop_request_bit_o = stop_q;
  assign serial_data_o = data_q;
  assign start_pending_o = pend_q;
  assign start_launch_o = launch_q;
  assign bus_owned_o = own_q;
  assign bus_busy_o = busy_prev_q;
endmodule // twowire_slave_tx_status

`default_nettype wire

//--- twowire_common.sv
// Shared constants, types and the multi-bit level synchroniser for the two-wire slave transmitter
`default_nettype none

package twowire_pkg;
  localparam logic [7:0] ST_OWN_READ = 8'hA8;
  localparam logic [7:0] ST_ARB_READ = 8'hB0;
  localparam logic [7:0] ST_DATA_ACK = 8'hB8;
  localparam logic [7:0] ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;
  localparam logic [7:0] ST_BUS_ERROR = 8'h00;
  localparam logic [7:0] PRESCALE_MASK = 8'hF8;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic LINE_LOW = 1'b0;
  localparam int ADDR_BITS = 7;
  localparam int DATA_BITS = 8;

  typedef enum logic [2:0] {
    L_IDLE,
    L_SKIP,
    L_ADDR,
    L_ADDR_ACK,
    L_HOLD,
    L_TX,
    L_TX_ACK,
    L_TX_POST
  } link_state_t;
endpackage

module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // bit_sync

`default_nettype wire

//--- twowire_slave_tx_status_assertions.sv
// Concurrent checks on the slave transmitter status ports
`default_nettype none

module twowire_slave_tx_status_checker
  import twowire_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] status_o,
  input wire logic step_done_flag_o,
  input wire logic ack_enable_o,
  input wire logic stop_request_bit_o,
  input wire logic start_pending_o,
  input wire logic start_launch_o,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic [7:0] serial_data_o,
  input wire logic ctrl_write_i,
  input wire logic ctrl_flag_i,
  input wire logic ctrl_ack_i,
  input wire logic ctrl_start_i,
  input wire logic ctrl_stop_i,
  input wire logic data_write_i,
  input wire logic [7:0] data_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic wr1;
  logic done;
  assign wr1 = ctrl_write_i && ctrl_flag_i && step_done_flag_o;
  assign done = status_o == ST_DATA_NACK || status_o == ST_LAST_ACK;
  AST_NO_INFO: assert property (!step_done_flag_o |-> status_o == ST_NO_INFO)
    else $error("status not idle code while flag clear");
  AST_MASKED: assert property (step_done_flag_o |-> (status_o & ~PRESCALE_MASK) == 8'h00)
    else $error("status low bits not zero");
  AST_LEAVE: assert property (wr1 && done |=> !step_done_flag_o)
    else $error("flag not cleared on leaving final state");
  AST_RECOVER: assert property (wr1 && ctrl_stop_i && status_o == ST_BUS_ERROR
      |=> !stop_request_bit_o && !step_done_flag_o)
    else $error("bus error recovery failed");
  AST_RELEASE: assert property (step_done_flag_o && status_o == ST_BUS_ERROR
      |-> !scl_oe_o && !sda_oe_o)
    else $error("lines held after bus error");
  AST_QUEUE: assert property (wr1 && ctrl_start_i && done |=> start_pending_o)
    else $error("start not queued");
  AST_LAUNCH: assert property (start_launch_o |-> $past(start_pending_o)
      ##1 (!start_launch_o && !start_pending_o))
    else $error("launch pulse wrong");
  AST_STRETCH: assert property (step_done_flag_o && (status_o == ST_OWN_READ ||
      status_o == ST_ARB_READ || status_o == ST_DATA_ACK) |-> scl_oe_o)
    else $error("clock not held while flag set");
  AST_LOAD: assert property (data_write_i |=> serial_data_o == $past(data_i))
    else $error("data register not loaded");
  AST_ACK_BIT: assert property (ctrl_write_i |=> ack_enable_o == $past(ctrl_ack_i))
    else $error("ack enable not written");
  cover property (step_done_flag_o && status_o == ST_LAST_ACK);
  cover property (step_done_flag_o && status_o == ST_BUS_ERROR);
  cover property (start_launch_o);
endmodule // twowire_slave_tx_status_checker

bind twowire_slave_tx_status twowire_slave_tx_status_checker chk_u (.clk_i, .reset_n_i,
  .status_o, .step_done_flag_o, .ack_enable_o, .stop_request_bit_o, .start_pending_o,
  .start_launch_o, .scl_oe_o, .sda_oe_o, .serial_data_o, .ctrl_write_i, .ctrl_flag_i,
  .ctrl_ack_i, .ctrl_start_i, .ctrl_stop_i, .data_write_i, .data_i);

`default_nettype wire

//--- twowire_master_model.sv
// Behavioural bus master receiver driving the open drain lines
`default_nettype none

module twowire_master_model (
  input wire logic scl_w_i,
  input wire logic sda_w_i,
  output logic scl_m_o,
  output logic sda_m_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int stuck = 0;
  initial begin
    scl_m_o = 1'b1;
    sda_m_o = 1'b1;
  end
  task automatic clk_bit(input logic b, output logic r);
    int n;
    n = 0;
    sda_m_o = b;
    #500;
    scl_m_o = 1'b1;
    while (!scl_w_i && n < 4000) begin
      n++;
      #125;
    end
    if (n == 4000) stuck++;
    #500;
    r = sda_w_i;
    #500;
    scl_m_o = 1'b0;
  endtask
  // Data bits only move while the clock is low; only start and stop move data with the clock high
  task automatic start();
    sda_m_o = 1'b1;
    #500;
    scl_m_o = 1'b1;
    #500;
    sda_m_o = 1'b0;
    #500;
    scl_m_o = 1'b0;
  endtask
  task automatic stop();
    sda_m_o = 1'b0;
    #500;
    scl_m_o = 1'b1;
    #500;
    sda_m_o = 1'b1;
    #1000;
  endtask
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], r);
    clk_bit(1'b1, ack);
  endtask
  task automatic get_byte(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
    clk_bit(mack, r);
  endtask
endmodule // twowire_master_model

`default_nettype wire

//--- twowire_slave_tx_status_test.sv
// Self-checking bench for the two-wire slave transmitter status logic
`default_nettype none

module twowire_slave_tx_status_test;
  import twowire_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, link_clk_i = 1'b0, reset_n_i = 1'b0, arb_lost_i = 1'b0;
  logic ctrl_write_i = 1'b0, ctrl_flag_i = 1'b0, ctrl_ack_i = 1'b0, ctrl_start_i = 1'b0;
  logic ctrl_stop_i = 1'b0, data_write_i = 1'b0, gce_i = 1'b0;
  logic [6:0] own_addr_i = 7'h35;
  logic [7:0] data_i = 8'h00, status_o, serial_data_o;
  logic scl_oe_o, sda_oe_o, scl_m, sda_m, flag, ack_o, sta_o, sto_o, pend_o, launch_o;
  wire logic scl_w = scl_m & ~scl_oe_o;
  wire logic sda_w = sda_m & ~sda_oe_o;
  int failures = 0, total_checks = 0, seed = 28, launches = 0;

  always #12.5 clk_i = ~clk_i;
  // Launch is a one-cycle pulse, so it is counted as it happens
  always @(posedge clk_i) begin
    if (launch_o === 1'b1) launches++;
  end
  initial begin
    #3.3;
    forever #62.5 link_clk_i = ~link_clk_i;
  end

  twowire_slave_tx_status dut_u (.clk_i, .reset_n_i, .link_clk_i, .scl_i(scl_w), .scl_o(),
    .scl_oe_o, .sda_i(sda_w), .sda_o(), .sda_oe_o, .own_addr_i,
    .general_call_enable_i(gce_i), .arb_lost_i, .ctrl_write_i, .ctrl_flag_i, .ctrl_ack_i,
    .ctrl_start_i, .ctrl_stop_i, .data_write_i, .data_i, .status_o,
    .step_done_flag_o(flag), .ack_enable_o(ack_o), .start_request_o(sta_o),
    .stop_request_bit_o(sto_o), .serial_data_o, .start_pending_o(pend_o),
    .start_launch_o(launch_o), .bus_owned_o(), .bus_busy_o());
  twowire_master_model mst (.scl_w_i(scl_w), .sda_w_i(sda_w), .scl_m_o(scl_m),
    .sda_m_o(sda_m));

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ctrl(input logic ack, input logic start_request, input logic stop_request);
    @(posedge clk_i);
    ctrl_write_i <= 1'b1;
    ctrl_flag_i <= 1'b1;
    ctrl_ack_i <= ack;
    ctrl_start_i <= start_request;
    ctrl_stop_i <= stop_request;
    @(posedge clk_i);
    ctrl_write_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic load(input logic [7:0] d);
    @(posedge clk_i);
    data_i <= d;
    data_write_i <= 1'b1;
    @(posedge clk_i);
    data_write_i <= 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic [7:0] code);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 400) begin
      failures++;
      conclude();
    end
    check(status_o, code);
  endtask
  function automatic logic [7:0] code_after(input logic ae, input logic nack);
    return nack ? ST_DATA_NACK : (ae ? ST_DATA_ACK : ST_LAST_ACK);
  endfunction
  task automatic run(input logic arb, input int nb, input logic fin_sta);
    logic a, ae, mk;
    logic [7:0] d, v;
    arb_lost_i <= arb;
    mst.start();
    mst.put_byte({own_addr_i, 1'b1}, a);
    check({7'h00, a}, 8'h00);
    wait_for(flag, arb ? ST_ARB_READ : ST_OWN_READ);
    for (int i = 0; i < nb; i++) begin
      d = 8'($random(seed));
      ae = (i < nb - 1);
      mk = !arb && !ae;
      load(d);
      ctrl(ae, 1'b0, 1'b0);
      mst.get_byte(mk, v);
      check(v, d);
      wait_for(flag, code_after(ae, mk));
    end
    ctrl(1'b0, fin_sta, 1'b0);
    check(status_o, ST_NO_INFO);
    if (arb) begin
      mst.get_byte(1'b1, v);
      check(v, 8'hFF);
    end
    check({7'h00, pend_o}, {7'h00, fin_sta});
    mst.stop();
  endtask

  initial begin
    logic r;
    repeat (2) @(posedge link_clk_i);
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    check(status_o, ST_NO_INFO);
    ctrl(1'b1, 1'b0, 1'b0);
    mst.start();
    repeat (3) mst.clk_bit(1'b1, r);
    mst.start();
    wait_for(flag, ST_BUS_ERROR);
    check({6'h00, scl_oe_o, sda_oe_o}, 8'h00);
    ctrl(1'b1, 1'b0, 1'b1);
    check({5'h00, flag, sto_o, ack_o}, 8'h01);
    mst.stop();
    run(1'b0, 3, 1'b1);
    check({7'h00, pend_o}, 8'h00);
    check(8'(launches), 8'h01);
    mst.start();
    mst.put_byte({own_addr_i, 1'b1}, r);
    check({6'h00, flag, r}, 8'h01);
    mst.stop();
    ctrl(1'b1, 1'b0, 1'b0);
    run(1'b1, 2, 1'b0);
    check(8'(mst.stuck), 8'h00);
    conclude();
  end
endmodule // twowire_slave_tx_status_test

`default_nettype wire
